/* File: liu_defines.vh */
// register map, field widths and reset values for the interrupt and pulse source control
`ifndef LIU_DEFINES_VH
`define LIU_DEFINES_VH

// ----------------------------------------------------------------------
// register interface widths
// ----------------------------------------------------------------------
`define LIU_ADDR_W        5
`define LIU_DATA_W        8
`define LIU_CH_N          8
`define LIU_CH_W          3
`define LIU_SAMPLE_W      7
`define LIU_SUM_W         8
`define LIU_GROUP_N       4

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LIU_LOS_STATUS    5'h04
`define LIU_DRV_STATUS    5'h05
`define LIU_LOS_IRQ_EN    5'h06
`define LIU_DRV_IRQ_EN    5'h07
`define LIU_LOS_IRQ_ST    5'h08
`define LIU_DRV_IRQ_ST    5'h09
`define LIU_AIS_STATUS    5'h13
`define LIU_AIS_IRQ_EN    5'h14
`define LIU_AIS_IRQ_ST    5'h15
`define LIU_PULSE_SRC     5'h19
`define LIU_OVF_IRQ_EN    5'h1A
`define LIU_OVF_IRQ_ST    5'h1B
`define LIU_RESERVED_BITS_A        5'h1C
`define LIU_RESERVED_BITS_B        5'h1D
`define LIU_TREC_EN       5'h1E
`define LIU_RESERVED_BITS_C        5'h1F

// ----------------------------------------------------------------------
// group indices of the interrupt cells
// ----------------------------------------------------------------------
`define LIU_GRP_LOS       0
`define LIU_GRP_DRV       1
`define LIU_GRP_AIS       2
`define LIU_GRP_OVF       3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LIU_REG_RESET     8'h00
`define LIU_BIT_RESET     1'b0
`define LIU_IRQ_IDLE      1'b1
// seed of the one-hot channel decode
`define LIU_CH_ONE        8'h01

`endif

/* File: liu_irq_cell.v */
// one interrupt group: enable mask, change detector and clear-on-read status
`timescale 1ns/1ps
`include "liu_defines.vh"

module liu_irq_cell (
   input  wire                      clk_sys,
   input  wire                      reset_n,
   input  wire [`LIU_DATA_W-1:0]    live_status,
   input  wire                      enable_wr,
   input  wire [`LIU_DATA_W-1:0]    wr_data,
   input  wire                      status_rd,
   output reg  [`LIU_DATA_W-1:0]    enable,
   output reg  [`LIU_DATA_W-1:0]    pending
);

   reg  [`LIU_DATA_W-1:0] live_prev;
   wire [`LIU_DATA_W-1:0] changed;
   wire [`LIU_DATA_W-1:0] next_pending;

   // ----------------------------------------------------------------------
   // change detection
   // ----------------------------------------------------------------------
   // a masked bit never enters the pending set, so the live value stays untouched
   assign changed      = (live_status ^ live_prev) & enable;
   // a change in the same cycle as the clearing read survives it
   assign next_pending = (status_rd ? `LIU_REG_RESET : pending) | changed;

   // enable mask, previous live value and sticky pending bits
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         enable    <= `LIU_REG_RESET;
         pending   <= `LIU_REG_RESET;
         live_prev <= `LIU_REG_RESET;
      end else begin
         if (enable_wr) begin
            enable <= wr_data;
         end
         pending   <= next_pending;
         live_prev <= live_status;
      end
   end

endmodule // liu_irq_cell

/* File: liu_irq_pulse_ctrl.v */
// per-channel pulse source, timing recovery, overflow check and interrupt aggregation
//
// What this block does
// - bit one selects custom waveform pulse
// - bit zero selects fixed rom pulse
// - reset clears control and status registers
// - overflow enable gates its own channel
// - flag overflow when sample sums exceed range
// - overflow status bit records channel change
// - reading interrupt status clears pending interrupt
// - bit one makes channel timing recovery
// - live status registers ignore host writes
// - enabled status change asserts interrupt pin
// - disabled enable bit never causes interrupt
// - masking leaves live status value untouched
// - interrupt status flags per-channel status change
// - samples are seven-bit two's complement values
`timescale 1ns/1ps
`include "liu_defines.vh"

module liu_irq_pulse_ctrl (
   input  wire                      clk_sys,
   input  wire                      reset_n,
   // host register port
   input  wire [`LIU_ADDR_W-1:0]    host_addr,
   input  wire [`LIU_DATA_W-1:0]    host_wr_data,
   input  wire                      host_wr,
   input  wire                      host_rd,
   output reg  [`LIU_DATA_W-1:0]    host_rd_data,
   output reg                       host_rd_valid,
   // live channel conditions
   input  wire [`LIU_CH_N-1:0]      loss_of_signal,
   input  wire [`LIU_CH_N-1:0]      driver_failure_monitor,
   input  wire [`LIU_CH_N-1:0]      alarm_indication_signal,
   // waveform sample pairs scanned by the custom waveform generator
   input  wire                      sample_valid,
   input  wire [`LIU_CH_W-1:0]      sample_channel,
   input  wire                      sample_first,
   input  wire                      sample_last,
   input  wire [`LIU_SAMPLE_W-1:0]  first_unit_interval,
   input  wire [`LIU_SAMPLE_W-1:0]  second_unit_interval,
   // channel controls
   output reg  [`LIU_CH_N-1:0]      pulse_source_custom,
   output reg  [`LIU_CH_N-1:0]      timing_recovery_mode,
   output reg  [`LIU_CH_N-1:0]      waveform_overflow,
   output reg                       irq_n
);

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   // all registers are eight bits wide
   // 04h loss of signal status, read only
   // 05h driver failure status, read only
   // 06h loss of signal interrupt enable
   // 07h driver failure interrupt enable
   // 08h loss of signal interrupt status
   // 09h driver failure interrupt status
   // 13h alarm status, read only
   // 14h alarm interrupt enable
   // 15h alarm interrupt status
   // 19h pulse source, 1 custom, 0 rom
   // 1ah overflow interrupt enable
   // 1bh overflow interrupt status
   // 1ch, 1dh and 1fh reserved, read zero
   // 1eh timing recovery enable
   // unmapped offsets read zero

   // ----------------------------------------------------------------------
   // operating notes
   // ----------------------------------------------------------------------
   // strobes are taken at the edge that sees them high
   // read data and valid follow that edge by one cycle
   // read data holds until the next read
   // read and write latency do not depend on the offset
   // channel controls follow a write by two edges
   // a live change sets pending at the next edge
   // the pin falls one edge after pending sets
   // the pin rises one edge after the clearing read
   // a scan verdict lands at the edge of its last pair
   // reset clears every register, the pin idles high
   // live inputs high at release raise nothing
   // a read clears every pending bit of its group
   // a change in the cycle of that read stays pending
   // a masked change is dropped, not held for later
   // a new enable does not report older changes
   // enable and status of one group share a cell
   // scans of two channels must not interleave
   // a scan of one pair has first and last high
   // sample inputs are ignored without valid
   // live conditions must already be on this clock
   // write and read strobes are never raised together
   // status and reserved writes are dropped
   // the pin is a registered level, never a pulse
   // overflow status is sticky and clears on read, like the other groups
   // offsets are hexadecimal
   // bit n of every register is channel n

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   reg  [`LIU_DATA_W-1:0]                pulse_source_select;
   reg  [`LIU_DATA_W-1:0]                timing_recovery_enable;
   reg                                   scan_overflow;
   reg  [`LIU_DATA_W-1:0]                next_rd_data;
   reg  [`LIU_GROUP_N-1:0]               grp_enable_wr;
   reg  [`LIU_GROUP_N-1:0]               grp_status_rd;
   wire [`LIU_SUM_W-1:0]                 sample_sum;
   wire                                  sample_overflow;
   wire                                  scan_hit;
   wire [`LIU_GROUP_N*`LIU_DATA_W-1:0]   grp_live;
   wire [`LIU_GROUP_N*`LIU_DATA_W-1:0]   grp_enable;
   wire [`LIU_GROUP_N*`LIU_DATA_W-1:0]   grp_pending;
   wire                                  any_pending;
   wire [`LIU_CH_N-1:0]                  scan_commit;
   wire [`LIU_CH_N-1:0]                  next_overflow;
   wire [`LIU_GROUP_N-1:0]               grp_active;
   wire [`LIU_DATA_W-1:0]                los_enable;
   wire [`LIU_DATA_W-1:0]                drv_enable;
   wire [`LIU_DATA_W-1:0]                ais_enable;
   wire [`LIU_DATA_W-1:0]                ovf_enable;
   wire [`LIU_DATA_W-1:0]                los_pending;
   wire [`LIU_DATA_W-1:0]                drv_pending;
   wire [`LIU_DATA_W-1:0]                ais_pending;
   wire [`LIU_DATA_W-1:0]                ovf_pending;

   // ----------------------------------------------------------------------
   // host write decode for the plain control registers
   // ----------------------------------------------------------------------
   // reserved and live status offsets have no write target here
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         pulse_source_select    <= `LIU_REG_RESET;
         timing_recovery_enable <= `LIU_REG_RESET;
      end else if (host_wr) begin
         case (host_addr)
            `LIU_PULSE_SRC: begin
               pulse_source_select <= host_wr_data;
            end
            `LIU_TREC_EN: begin
               timing_recovery_enable <= host_wr_data;
            end
            default: begin
               // status, reserved and unmapped writes are dropped
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // channel controls
   // ----------------------------------------------------------------------
   // registered copies keep the datapath controls glitch free
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         pulse_source_custom  <= `LIU_REG_RESET;
         timing_recovery_mode <= `LIU_REG_RESET;
      end else begin
         pulse_source_custom  <= pulse_source_select;      // 1 custom, 0 rom
         timing_recovery_mode <= timing_recovery_enable;   // stand-alone recovery
      end
   end

   // ----------------------------------------------------------------------
   // waveform overflow check
   // ----------------------------------------------------------------------
   // sign extend both seven-bit samples so the eighth bit catches the carry
   assign sample_sum = {first_unit_interval[`LIU_SAMPLE_W-1], first_unit_interval}
                     + {second_unit_interval[`LIU_SAMPLE_W-1], second_unit_interval};
   // result outside 40h..3Fh when the two top bits disagree
   assign sample_overflow = sample_sum[`LIU_SUM_W-1] ^ sample_sum[`LIU_SUM_W-2];
   // the first pair of a scan restarts the accumulated verdict
   assign scan_hit = sample_overflow | (scan_overflow & ~sample_first);

   // one-hot of the channel whose scan ends at this pair
   assign scan_commit = (sample_valid & sample_last) ? (`LIU_CH_ONE << sample_channel)
                                                     : `LIU_REG_RESET;

   // one slice per channel; only the scanned channel takes the verdict
   genvar c;
   generate
      for (c = 0; c < `LIU_CH_N; c = c + 1) begin : g_chan
         assign next_overflow[c] = scan_commit[c] ? scan_hit : waveform_overflow[c];
      end
   endgenerate

   // one scan runs at a time; a verdict stands until its channel is scanned again
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         scan_overflow     <= `LIU_BIT_RESET;
         waveform_overflow <= `LIU_REG_RESET;
      end else begin
         if (sample_valid) begin
            scan_overflow <= scan_hit;
         end
         waveform_overflow <= next_overflow;
      end
   end

   // ----------------------------------------------------------------------
   // interrupt groups
   // ----------------------------------------------------------------------
   assign grp_live = {waveform_overflow, alarm_indication_signal,
                      driver_failure_monitor, loss_of_signal};

   // enable writes and clearing reads per group
   always @* begin
      grp_enable_wr = {`LIU_GROUP_N{1'b0}};
      grp_status_rd = {`LIU_GROUP_N{1'b0}};
      grp_enable_wr[`LIU_GRP_LOS] = host_wr & (host_addr == `LIU_LOS_IRQ_EN);
      grp_enable_wr[`LIU_GRP_DRV] = host_wr & (host_addr == `LIU_DRV_IRQ_EN);
      grp_enable_wr[`LIU_GRP_AIS] = host_wr & (host_addr == `LIU_AIS_IRQ_EN);
      grp_enable_wr[`LIU_GRP_OVF] = host_wr & (host_addr == `LIU_OVF_IRQ_EN);
      grp_status_rd[`LIU_GRP_LOS] = host_rd & (host_addr == `LIU_LOS_IRQ_ST);
      grp_status_rd[`LIU_GRP_DRV] = host_rd & (host_addr == `LIU_DRV_IRQ_ST);
      grp_status_rd[`LIU_GRP_AIS] = host_rd & (host_addr == `LIU_AIS_IRQ_ST);
      grp_status_rd[`LIU_GRP_OVF] = host_rd & (host_addr == `LIU_OVF_IRQ_ST);
   end

   // one cell per group: loss of signal, driver failure, alarm, overflow
   genvar g;
   generate
      for (g = 0; g < `LIU_GROUP_N; g = g + 1) begin : g_irq
         liu_irq_cell u_cell (
            .clk_sys     (clk_sys),
            .reset_n     (reset_n),
            .live_status (grp_live[g*`LIU_DATA_W +: `LIU_DATA_W]),
            .enable_wr   (grp_enable_wr[g]),
            .wr_data     (host_wr_data),
            .status_rd   (grp_status_rd[g]),
            .enable      (grp_enable[g*`LIU_DATA_W +: `LIU_DATA_W]),
            .pending     (grp_pending[g*`LIU_DATA_W +: `LIU_DATA_W])
         );
         assign grp_active[g] = |grp_pending[g*`LIU_DATA_W +: `LIU_DATA_W];
      end
   endgenerate

   // ----------------------------------------------------------------------
   // group views
   // ----------------------------------------------------------------------
   // named slices of the packed group buses, so the read mux reads as a table
   assign los_enable  = grp_enable[`LIU_GRP_LOS*`LIU_DATA_W +: `LIU_DATA_W];
   assign drv_enable  = grp_enable[`LIU_GRP_DRV*`LIU_DATA_W +: `LIU_DATA_W];
   assign ais_enable  = grp_enable[`LIU_GRP_AIS*`LIU_DATA_W +: `LIU_DATA_W];
   assign ovf_enable  = grp_enable[`LIU_GRP_OVF*`LIU_DATA_W +: `LIU_DATA_W];
   assign los_pending = grp_pending[`LIU_GRP_LOS*`LIU_DATA_W +: `LIU_DATA_W];
   assign drv_pending = grp_pending[`LIU_GRP_DRV*`LIU_DATA_W +: `LIU_DATA_W];
   assign ais_pending = grp_pending[`LIU_GRP_AIS*`LIU_DATA_W +: `LIU_DATA_W];
   assign ovf_pending = grp_pending[`LIU_GRP_OVF*`LIU_DATA_W +: `LIU_DATA_W];

   // pending bits only ever enter when enabled, so any set bit holds the pin
   assign any_pending = |grp_active;

   // interrupt pin, registered; released one edge after the last clear
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         irq_n <= `LIU_IRQ_IDLE;
      end else begin
         irq_n <= ~any_pending;
      end
   end

   // ----------------------------------------------------------------------
   // host read mux
   // ----------------------------------------------------------------------
   // the pending value shown is the one before this read clears it
   always @* begin
      next_rd_data = `LIU_REG_RESET;
      case (host_addr)
         `LIU_LOS_STATUS: next_rd_data = loss_of_signal;
         `LIU_DRV_STATUS: next_rd_data = driver_failure_monitor;
         `LIU_AIS_STATUS: next_rd_data = alarm_indication_signal;
         `LIU_LOS_IRQ_EN: next_rd_data = los_enable;
         `LIU_DRV_IRQ_EN: next_rd_data = drv_enable;
         `LIU_AIS_IRQ_EN: next_rd_data = ais_enable;
         `LIU_OVF_IRQ_EN: next_rd_data = ovf_enable;
         `LIU_LOS_IRQ_ST: next_rd_data = los_pending;
         `LIU_DRV_IRQ_ST: next_rd_data = drv_pending;
         `LIU_AIS_IRQ_ST: next_rd_data = ais_pending;
         `LIU_OVF_IRQ_ST: next_rd_data = ovf_pending;
         `LIU_PULSE_SRC:  next_rd_data = pulse_source_select;
         `LIU_TREC_EN:    next_rd_data = timing_recovery_enable;
         `LIU_RESERVED_BITS_A:     next_rd_data = `LIU_REG_RESET;
         `LIU_RESERVED_BITS_B:     next_rd_data = `LIU_REG_RESET;
         `LIU_RESERVED_BITS_C:     next_rd_data = `LIU_REG_RESET;
         default:         next_rd_data = `LIU_REG_RESET;
      endcase
   end

   // read data register; valid pulses one cycle after the read strobe
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         host_rd_data  <= `LIU_REG_RESET;
         host_rd_valid <= `LIU_BIT_RESET;
      end else begin
         host_rd_valid <= host_rd;
         if (host_rd) begin
            host_rd_data <= next_rd_data;
         end
      end
   end

endmodule // liu_irq_pulse_ctrl

/* File: liu_irq_pulse_ctrl_checker.sv */
// port-level assertions for the interrupt and pulse source control block
`timescale 1ns/1ps
module liu_irq_pulse_ctrl_checker (
   input wire       clk_sys,
   input wire       reset_n,
   input wire [4:0] host_addr,
   input wire [7:0] host_wr_data,
   input wire       host_wr,
   input wire       host_rd,
   input wire [7:0] host_rd_data,
   input wire       host_rd_valid,
   input wire [7:0] loss_of_signal,
   input wire [7:0] driver_failure_monitor,
   input wire [7:0] alarm_indication_signal,
   input wire       sample_valid,
   input wire [2:0] sample_channel,
   input wire       sample_first,
   input wire       sample_last,
   input wire [6:0] first_unit_interval,
   input wire [6:0] second_unit_interval,
   input wire [7:0] pulse_source_custom,
   input wire [7:0] timing_recovery_mode,
   input wire [7:0] waveform_overflow,
   input wire       irq_n
);
   default clocking cb @(posedge clk_sys); endclocking
   // ----------------------------------------------------------------------
   // helper logic: pair overflow and recent change history
   // ----------------------------------------------------------------------
   wire [7:0]  pair_sum = {first_unit_interval[6], first_unit_interval}
                        + {second_unit_interval[6], second_unit_interval};
   wire        pair_ovf = pair_sum[7] != pair_sum[6]; // sign bits disagree past 7 bits
   wire [31:0] live     = {loss_of_signal, driver_failure_monitor,
                           alarm_indication_signal, waveform_overflow};
   reg  [31:0] prev_live;
   reg  [3:0]  chg_hist;
   // a window of four edges covers the detector and pin register latency
   always @(posedge clk_sys) begin
      prev_live <= live;
      chg_hist  <= {chg_hist[2:0], live != prev_live};
   end
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_rd_valid; disable iff (!reset_n) host_rd |=> host_rd_valid; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
   property p_reset; !reset_n |=> irq_n && pulse_source_custom == 8'h00
      && timing_recovery_mode == 8'h00 && waveform_overflow == 8'h00; endproperty
   a_reset: assert property (p_reset) else $error("reset values wrong");
   property p_src; disable iff (!reset_n) host_wr && host_addr == 5'h19
      |=> ##1 pulse_source_custom == $past(host_wr_data, 2); endproperty
   a_src: assert property (p_src) else $error("pulse source wrong");
   property p_trec; disable iff (!reset_n) host_wr && host_addr == 5'h1E
      |=> ##1 timing_recovery_mode == $past(host_wr_data, 2); endproperty
   a_trec: assert property (p_trec) else $error("timing recovery wrong");
   property p_reserved_bits; disable iff (!reset_n) host_rd && host_addr >= 5'h1C
      && host_addr != 5'h1E |=> host_rd_data == 8'h00; endproperty
   a_reserved_bits: assert property (p_reserved_bits) else $error("reserved read nonzero");
   property p_ovf; disable iff (!reset_n) sample_valid && sample_last
      && (pair_ovf || sample_first)
      |=> waveform_overflow[$past(sample_channel)] == $past(pair_ovf); endproperty
   a_ovf: assert property (p_ovf) else $error("overflow verdict wrong");
   property p_irq_rise; disable iff (!reset_n)
      $rose(irq_n) |-> $past(host_rd, 2) || $past(host_rd, 3); endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("pin released unread");
   property p_irq_fall; disable iff (!reset_n) $fell(irq_n) |-> |chg_hist; endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("pin fell uncaused");
endmodule // liu_irq_pulse_ctrl_checker

bind liu_irq_pulse_ctrl liu_irq_pulse_ctrl_checker u_chk (.*);

/* File: liu_host_model.sv */
// host processor model driving the strobe register port
`timescale 1ns/1ps
module liu_host_model (
   input  wire       clk_sys,
   output reg  [4:0] host_addr,
   output reg  [7:0] host_wr_data,
   output reg        host_wr,
   output reg        host_rd,
   input  wire [7:0] host_rd_data,
   input  wire       host_rd_valid
);
   initial begin
      {host_addr, host_wr_data, host_wr, host_rd} = 15'h0000;
   end
   // one-cycle write strobe; reserved offsets only ever see zeros
   task wr(input [4:0] a, input [7:0] d);
      begin
         @(posedge clk_sys); #1;
         host_addr = a;
         host_wr_data = (a >= 5'h1C && a != 5'h1E) ? 8'h00 : d;
         host_wr = 1'b1;
         @(posedge clk_sys); #1;
         host_wr = 1'b0;
         host_wr_data = ~host_wr_data; // released data must not look valid
      end
   endtask
   // answer is registered at the edge that takes the strobe
   task rd(input [4:0] a, output [7:0] d, output v);
      begin
         @(posedge clk_sys); #1;
         host_addr = a;
         host_rd = 1'b1;
         @(posedge clk_sys); #1;
         host_rd = 1'b0;
         v = host_rd_valid;
         d = host_rd_data;
      end
   endtask
endmodule // liu_host_model

/* File: liu_irq_pulse_ctrl_tb_top.sv */
// self-checking bench for the interrupt and pulse source control block
`timescale 1ns/1ps
module liu_irq_pulse_ctrl_tb_top;
   reg        clk_sys, reset_n, sample_valid, sample_first, sample_last, v;
   reg  [7:0] loss_of_signal, driver_failure_monitor, alarm_indication_signal, d, e;
   reg  [2:0] sample_channel;
   reg  [6:0] first_unit_interval, second_unit_interval;
   wire [4:0] host_addr;
   wire [7:0] host_wr_data, host_rd_data, pulse_source_custom;
   wire [7:0] timing_recovery_mode, waveform_overflow;
   wire       host_wr, host_rd, host_rd_valid, irq_n;
   integer    n_fail, comparisons, i;
   liu_irq_pulse_ctrl uut (.*);
   liu_host_model host (.*);
   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   task chk(input [8*8:1] name, input [7:0] ex, input [7:0] got);
      begin
         comparisons = comparisons + 1;
         if (got !== ex) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %0s expected %h seen %h", name, ex, got);
         end
      end
   endtask
   task rchk(input [4:0] a, input [7:0] ex);
      begin
         host.rd(a, d, v);
         chk("valid", 8'h01, {7'h00, v});
         chk("rd_data", ex, d);
      end
   endtask
   // bounded wait; running out of cycles counts as a mismatch
   task wait_irq(input lvl);
      integer k;
      begin
         for (k = 0; k < 8 && irq_n !== lvl; k = k + 1) @(posedge clk_sys) #1;
         chk("irq_n", {7'h00, lvl}, {7'h00, irq_n});
         if (irq_n !== lvl) conclude; // out of cycles: report at once
      end
   endtask
   task scan(input [2:0] ch, input [6:0] a0, b0, a1, b1);
      begin
         @(posedge clk_sys); #1;
         {sample_valid, sample_first, sample_last, sample_channel} = {3'b110, ch};
         {first_unit_interval, second_unit_interval} = {a0, b0};
         @(posedge clk_sys); #1;
         {sample_first, sample_last} = 2'b01;
         {first_unit_interval, second_unit_interval} = {a1, b1};
         @(posedge clk_sys); #1;
         {sample_valid, sample_last} = 2'b00;
      end
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task t_ctrl;
      begin
         rchk(5'h19, 8'h00);
         rchk(5'h1A, 8'h00);
         rchk(5'h1B, 8'h00);
         rchk(5'h1E, 8'h00);
         host.wr(5'h19, 8'hA5);
         host.wr(5'h1E, 8'h5A);
         @(posedge clk_sys) #1;
         chk("src", 8'hA5, pulse_source_custom);
         chk("trec", 8'h5A, timing_recovery_mode);
         rchk(5'h1E, 8'h5A);
         for (i = 0; i < 3; i = i + 1) host.wr(5'h1C + i + (i / 2), 8'hFF);
         rchk(5'h1C, 8'h00);
         rchk(5'h1D, 8'h00);
         rchk(5'h1F, 8'h00);
         loss_of_signal = 8'h3C;
         host.wr(5'h04, 8'hFF);
         host.wr(5'h1B, 8'hFF);
         rchk(5'h04, 8'h3C);
         rchk(5'h1B, 8'h00);
         chk("irq_n", 8'h01, {7'h00, irq_n});
         $display("t_ctrl done");
      end
   endtask
   // three live groups: bit 0 enabled, bit 1 masked, both toggled together
   task t_groups;
      begin
         for (i = 0; i < 3; i = i + 1) begin
            host.wr(i == 2 ? 5'h14 : 5'h06 + i, 8'h01);
            rchk(i == 2 ? 5'h14 : 5'h06 + i, 8'h01);
            case (i)
               0: begin
                  loss_of_signal = loss_of_signal ^ 8'h03;
                  e = loss_of_signal;
               end
               1: begin
                  driver_failure_monitor = 8'h03;
                  e = 8'h03;
               end
               default: begin
                  alarm_indication_signal = 8'h03;
                  e = 8'h03;
               end
            endcase
            wait_irq(1'b0);
            rchk(i == 2 ? 5'h15 : 5'h08 + i, 8'h01);
            wait_irq(1'b1);
            rchk(i == 2 ? 5'h13 : 5'h04 + i, e);
            host.wr(i == 2 ? 5'h14 : 5'h06 + i, 8'h00);
         end
         $display("t_groups done");
      end
   endtask
   task t_ovf;
      begin
         host.wr(5'h1A, 8'h04);
         host.wr(5'h06, 8'h01);
         scan(3'd2, 7'h3F, 7'h01, 7'h00, 7'h00);
         chk("ovf", 8'h04, waveform_overflow);
         loss_of_signal = loss_of_signal ^ 8'h01;
         wait_irq(1'b0);
         rchk(5'h1B, 8'h04);
         repeat (3) @(posedge clk_sys) #1;
         chk("irq_n", 8'h00, {7'h00, irq_n});
         rchk(5'h08, 8'h01);
         wait_irq(1'b1);
         scan(3'd3, 7'h3F, 7'h00, 7'h40, 7'h00);
         scan(3'd5, 7'h00, 7'h00, 7'h40, 7'h7F);
         chk("ovf", 8'h24, waveform_overflow);
         repeat (4) @(posedge clk_sys) #1;
         chk("irq_n", 8'h01, {7'h00, irq_n});
         rchk(5'h1B, 8'h00);
         $display("t_ovf done");
      end
   endtask
   // ----------------------------------------------------------------------
   // clock, reset, sequence and watchdog
   // ----------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {n_fail, comparisons} = 64'd0;
      {reset_n, sample_valid, sample_first, sample_last, sample_channel} = 7'h00;
      {loss_of_signal, driver_failure_monitor, alarm_indication_signal} = 24'h000000;
      {first_unit_interval, second_unit_interval} = 14'h0000;
      repeat (12) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      t_ctrl;
      t_groups;
      t_ovf;
      conclude;
   end
   initial begin
      #100000 n_fail = n_fail + 1;
      conclude;
   end
endmodule // liu_irq_pulse_ctrl_tb_top
